// File: pkg/gdr_pkg.sv
package gdr_pkg;

	// ==========================================================
	// Register map: relative addresses of the readback words.
	localparam logic [15:0] REG_BASE_NUMBER    = 16'h9C41;
	localparam logic [15:0] ADDR_FLOW_RATE     = 16'h0000;
	localparam logic [15:0] ADDR_ALARM1_THRESH = 16'h0001;
	localparam logic [15:0] ADDR_ALARM2_THRESH = 16'h0002;
	localparam logic [15:0] ADDR_ALARM_MODE    = 16'h0003;
	localparam logic [15:0] ADDR_ALARM1_DELAY  = 16'h0004;
	localparam logic [15:0] ADDR_ALARM2_DELAY  = 16'h0005;
	localparam logic [15:0] ADDR_ZERO_SUPPRESS = 16'h0006;
	localparam logic [15:0] ADDR_GAS_NAME_12   = 16'h0008;
	localparam logic [15:0] ADDR_GAS_NAME_34   = 16'h0009;
	localparam logic [15:0] ADDR_UNIT          = 16'h000A;
	localparam logic [15:0] ADDR_SERIAL_12     = 16'h000C;
	localparam logic [15:0] ADDR_SERIAL_34     = 16'h000D;
	localparam logic [15:0] ADDR_SERIAL_56     = 16'h000E;
	localparam logic [15:0] ADDR_SERIAL_78     = 16'h000F;
	localparam logic [15:0] ADDR_TEST_MODE     = 16'h0010;
	localparam logic [15:0] ADDR_TEST_GAS      = 16'h0011;
	localparam logic [15:0] ADDR_SENSOR_CURR   = 16'h0012;
	localparam logic [15:0] ADDR_SENSITIVITY   = 16'h0013;
	localparam logic [15:0] ADDR_CAL_CODE_12   = 16'h0014;
	localparam logic [15:0] ADDR_CAL_CODE_34   = 16'h0015;
	localparam logic [15:0] ADDR_CAL_LEVEL     = 16'h0016;
	localparam logic [15:0] ADDR_LIN_POINT_1   = 16'h0018;
	localparam int          REG_SLOTS          = 25;

	// ==========================================================
	// Protocol codes and word encodings.
	localparam logic [7:0]  FUNC_READ_HOLDING  = 8'h03;
	localparam logic [7:0]  EXC_FUNC_FLAG      = 8'h80;
	localparam logic [7:0]  EXC_NONE           = 8'h00;
	localparam logic [7:0]  EXC_ILLEGAL_FUNC   = 8'h01;
	localparam logic [7:0]  EXC_ILLEGAL_ADDR   = 8'h02;
	localparam logic [7:0]  EXC_ILLEGAL_VALUE  = 8'h03;
	localparam logic [15:0] MAX_QUANTITY       = 16'h007D;
	localparam logic [7:0]  ASCII_SPACE        = 8'h20;
	localparam logic [15:0] MODE_HIGH_HIGH     = 16'h0000;
	localparam logic [15:0] MODE_LOW_LOW       = 16'h0001;
	localparam logic [15:0] MODE_HIGH_LOW      = 16'h0002;
	localparam logic [15:0] UNIT_NONE          = 16'h0000;
	localparam logic [15:0] UNIT_PPM           = 16'h000A;
	localparam logic [15:0] UNIT_PPB           = 16'h0014;
	localparam logic [15:0] UNIT_PERCENT       = 16'h001E;
	localparam logic [15:0] UNIT_PERCENT_LEL   = 16'h0028;
	localparam logic [15:0] TEST_MODE_ON       = 16'h0001;
	localparam logic [15:0] TEST_MODE_OFF      = 16'h0000;
	localparam logic [15:0] WORD_RESET         = 16'h0000;

	// ==========================================================
	// Types.
	typedef enum logic [1:0] {
		GDR_MODE_HH,
		GDR_MODE_LL,
		GDR_MODE_HL
	} gdr_alarm_mode_t;

	typedef enum logic [2:0] {
		GDR_UNIT_NONE,
		GDR_UNIT_PPM,
		GDR_UNIT_PPB,
		GDR_UNIT_PERCENT,
		GDR_UNIT_LEL
	} gdr_unit_t;

	// Live detector values; character 0 is the first character.
	typedef struct packed {
		logic [15:0]      flowRate;
		logic [15:0]      firstAlarmThreshold;
		logic [15:0]      secondAlarmThreshold;
		gdr_alarm_mode_t  alarmMode;
		logic [15:0]      firstAlarmDelay;
		logic [15:0]      secondAlarmDelay;
		logic [15:0]      zeroSuppression;
		logic [7:0][7:0]  gasName;
		logic [3:0]       gasNameLength;
		gdr_unit_t        unit;
		logic [7:0][7:0]  serialChars;
		logic [3:0]       serialLength;
		logic             testModeActive;
		logic [15:0]      testGasLevel;
		logic [15:0]      sensorCurrentScaled;
		logic [15:0]      sensitivityScaled;
		logic [2:0][7:0]  calCode;
		logic [15:0]      calGasLevel;
		logic [7:0]       linInputPercent;
		logic [7:0]       linOutputPercent;
	} gdr_values_t;

	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] startAddr;
		logic [15:0] quantity;
	} gdr_req_t;

	typedef struct packed {
		logic [15:0] word;
		logic        last;
	} gdr_resp_t;

	typedef struct packed {
		logic [7:0] func;
		logic [7:0] code;
	} gdr_exc_t;

endpackage

// File: hw/gdr_readback_registers.sv
// Overview of operation
// - Requests name relative addresses; register 40001 is relative address zero.
// - Word 0x0 returns measured flow rate in millilitres, unsigned.
// - Words 0x1 and 0x2 return alarm thresholds in percent of full scale.
// - Alarm mode word: 0 high-high, 1 low-low, 2 high-low.
// - Words 0x4 and 0x5 return alarm delays in seconds.
// - Word 0x6 returns zero suppression percentage, oxygen band around 21vol%.
// - Gas name: four ASCII characters, earlier in high byte, space padded.
// - Names longer than four characters return only the first four.
// - Unit word: 0 none, 10 ppm, 20 ppb, 30 percent, 40 LEL.
// - Serial: eight ASCII characters in four words, high byte first, space padded.
// - Test mode word reads 1 while active, 0 while inactive.
// - Test gas concentration word in percent, unsigned.
// - Sensor current word is milliamperes times 100.
// - Sensitivity word is factor times 100.
// - Calibration code: three characters in two words, fourth byte space.
// - Calibration gas concentration word in percent, unsigned.
// - Linearisation point: input percent high byte, output percent low byte.
// - Unmapped register address answers exception code 2.
// - Exception answer carries received function code plus 0x80.
module gdr_readback_registers (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 reset,
	// Live detector values.
	input  wire gdr_pkg::gdr_values_t values,
	// Decoded read request from the protocol front end.
	input  wire logic                 reqValid,
	input  wire gdr_pkg::gdr_req_t    req,
	output logic                      reqReady,
	// Response words.
	output logic                      respValid,
	output gdr_pkg::gdr_resp_t        resp,
	// Exception answer.
	output logic                      excValid,
	output gdr_pkg::gdr_exc_t         exc
);

	// ==========================================================
	// Timing of one request.
	// A request is taken at a rising edge where reqValid and reqReady are both high.
	// The live values are copied into snapWords at that same edge, so every word
	// of the answer shows the detector as it stood when the request was taken.
	// reqReady falls at the accepting edge and stays low until the answer ends.
	// Function code and quantity are judged at once; a fault there is answered
	// one cycle after acceptance, ahead of any address check.
	// Addresses are then checked one per cycle, from startAddr upwards.
	// The first unmapped address ends the request with an address exception.
	// When all addresses pass, the walker rewinds to startAddr and the words
	// stream out one per cycle, with resp.last set on the final word.
	// A request of q words that succeeds ends 2q cycles after acceptance.
	// reqReady rises at the same edge as excValid or the final respValid,
	// so the next request can be taken at the following edge.
	// A front end must hold reqValid and req steady until it sees reqReady.
	// excValid lasts one cycle, respValid one cycle per word (q cycles in a row for q words); resp and exc keep
	// their contents until the next word or exception overwrites them or reset clears them.

	// Hazard: snapWords holds only REG_SLOTS words, so the stream index is the
	// low five bits of curAddr; the address check keeps that index in range.
	// Limitation: a request that touches a hole is refused as a whole, and a
	// partial answer is never sent.
	// Limitation: exc.func wraps around for a received function code of 0x80
	// or above, since the field is one byte wide.

	// ==========================================================
	// Word map of the bank, by relative address.
	// Address 0x00 holds the measured flow rate.
	// Addresses 0x01 and 0x02 hold the first and second alarm thresholds.
	// Address 0x03 holds the alarm mode code.
	// Addresses 0x04 and 0x05 hold the first and second alarm delays.
	// Address 0x06 holds the zero suppression value.
	// Address 0x07 is a hole and is refused.
	// Addresses 0x08 and 0x09 hold the target gas name, two characters each.
	// Address 0x0A holds the measurement unit code.
	// Address 0x0B is a hole and is refused.
	// Addresses 0x0C to 0x0F hold the sensor serial text, two characters each.
	// Address 0x10 holds the test mode state.
	// Address 0x11 holds the test gas concentration.
	// Addresses 0x12 and 0x13 hold the scaled sensor current and sensitivity.
	// Addresses 0x14 and 0x15 hold the calibration gas code and a space.
	// Address 0x16 holds the calibration gas concentration.
	// Address 0x17 is a hole and is refused.
	// Address 0x18 holds the first linearisation point.
	// Every address above 0x18 is refused.

	// Text words carry the earlier character in the high byte.
	// A character position at or beyond the given length reads as a space.
	// Only four name characters exist in the map, so longer names are cut.
	// The calibration code always ends with a space in its fourth byte.

	// ==========================================================
	// Word formatting helpers.

	// Returns a character, or a space where the text has ended.
	function automatic logic [7:0] padChar(
		input logic [7:0] c,
		input logic [3:0] pos,
		input logic [3:0] len
	);
		padChar = (pos < len) ? c : gdr_pkg::ASCII_SPACE;
	endfunction

	// Builds the word that a given relative address returns.
	function automatic logic [15:0] wordAt(
		input logic [15:0]          addr,
		input gdr_pkg::gdr_values_t v
	);
		logic [15:0] w;
		w = gdr_pkg::WORD_RESET;
		case (addr)
			gdr_pkg::ADDR_FLOW_RATE:     w = v.flowRate;
			gdr_pkg::ADDR_ALARM1_THRESH: w = v.firstAlarmThreshold;
			gdr_pkg::ADDR_ALARM2_THRESH: w = v.secondAlarmThreshold;
			gdr_pkg::ADDR_ALARM_MODE:
			begin
				case (v.alarmMode)
					gdr_pkg::GDR_MODE_LL: w = gdr_pkg::MODE_LOW_LOW;
					gdr_pkg::GDR_MODE_HL: w = gdr_pkg::MODE_HIGH_LOW;
					default:              w = gdr_pkg::MODE_HIGH_HIGH;
				endcase
			end
			gdr_pkg::ADDR_ALARM1_DELAY:  w = v.firstAlarmDelay;
			gdr_pkg::ADDR_ALARM2_DELAY:  w = v.secondAlarmDelay;
			gdr_pkg::ADDR_ZERO_SUPPRESS: w = v.zeroSuppression;
			// Only character positions 0 to 3 are ever fetched, so longer names truncate.
			gdr_pkg::ADDR_GAS_NAME_12:
				w = {padChar(v.gasName[0], 4'h0, v.gasNameLength),
				     padChar(v.gasName[1], 4'h1, v.gasNameLength)};
			gdr_pkg::ADDR_GAS_NAME_34:
				w = {padChar(v.gasName[2], 4'h2, v.gasNameLength),
				     padChar(v.gasName[3], 4'h3, v.gasNameLength)};
			gdr_pkg::ADDR_UNIT:
			begin
				case (v.unit)
					gdr_pkg::GDR_UNIT_PPM:     w = gdr_pkg::UNIT_PPM;
					gdr_pkg::GDR_UNIT_PPB:     w = gdr_pkg::UNIT_PPB;
					gdr_pkg::GDR_UNIT_PERCENT: w = gdr_pkg::UNIT_PERCENT;
					gdr_pkg::GDR_UNIT_LEL:     w = gdr_pkg::UNIT_PERCENT_LEL;
					default:                   w = gdr_pkg::UNIT_NONE;
				endcase
			end
			gdr_pkg::ADDR_SERIAL_12:
				w = {padChar(v.serialChars[0], 4'h0, v.serialLength),
				     padChar(v.serialChars[1], 4'h1, v.serialLength)};
			gdr_pkg::ADDR_SERIAL_34:
				w = {padChar(v.serialChars[2], 4'h2, v.serialLength),
				     padChar(v.serialChars[3], 4'h3, v.serialLength)};
			gdr_pkg::ADDR_SERIAL_56:
				w = {padChar(v.serialChars[4], 4'h4, v.serialLength),
				     padChar(v.serialChars[5], 4'h5, v.serialLength)};
			gdr_pkg::ADDR_SERIAL_78:
				w = {padChar(v.serialChars[6], 4'h6, v.serialLength),
				     padChar(v.serialChars[7], 4'h7, v.serialLength)};
			gdr_pkg::ADDR_TEST_MODE:
				w = v.testModeActive ? gdr_pkg::TEST_MODE_ON : gdr_pkg::TEST_MODE_OFF;
			gdr_pkg::ADDR_TEST_GAS:      w = v.testGasLevel;
			gdr_pkg::ADDR_SENSOR_CURR:   w = v.sensorCurrentScaled;
			gdr_pkg::ADDR_SENSITIVITY:   w = v.sensitivityScaled;
			gdr_pkg::ADDR_CAL_CODE_12:   w = {v.calCode[0], v.calCode[1]};
			gdr_pkg::ADDR_CAL_CODE_34:   w = {v.calCode[2], gdr_pkg::ASCII_SPACE};
			gdr_pkg::ADDR_CAL_LEVEL:     w = v.calGasLevel;
			gdr_pkg::ADDR_LIN_POINT_1:   w = {v.linInputPercent, v.linOutputPercent};
			default:                     w = gdr_pkg::WORD_RESET;
		endcase
		wordAt = w;
	endfunction

	// Tells whether a relative address holds a readback word.
	function automatic logic isMapped(input logic [15:0] addr);
		isMapped = (addr <= gdr_pkg::ADDR_LIN_POINT_1) &&
		           (addr != 16'h0007) && (addr != 16'h000B) && (addr != 16'h0017);
	endfunction

	// ==========================================================
	// Control state.
	typedef enum logic [1:0] {
		GDR_IDLE,
		GDR_CHECK,
		GDR_STREAM
	} gdr_state_t;

	gdr_state_t  state;
	logic [15:0] curAddr;
	logic [15:0] remaining;
	logic [15:0] startAddr;
	logic [15:0] quantity;
	logic [7:0]  reqFunc;
	logic [7:0]  preCode;
	logic [15:0] snapWords [0:gdr_pkg::REG_SLOTS-1];
	logic        accept;
	logic [7:0]  next_preCode;
	logic        lastStep;
	logic        checkFail;
	logic        streamDone;

	// A request is taken only while the block is idle.
	assign accept = reqValid && reqReady;

	// Function and quantity faults are known as soon as the request arrives.
	always_comb
	begin
		if (req.func != gdr_pkg::FUNC_READ_HOLDING)
			next_preCode = gdr_pkg::EXC_ILLEGAL_FUNC;
		else if ((req.quantity == 16'h0000) || (req.quantity > gdr_pkg::MAX_QUANTITY))
			next_preCode = gdr_pkg::EXC_ILLEGAL_VALUE;
		else
			next_preCode = gdr_pkg::EXC_NONE;
	end

	// ==========================================================
	// Snapshot of every word, taken when a request is accepted.
	for (genvar g = 0; g < gdr_pkg::REG_SLOTS; g++)
	begin : gSnap
		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
				snapWords[g] <= gdr_pkg::WORD_RESET;
			else if (accept)
				snapWords[g] <= wordAt(16'(g), values);
		end
	end

	// ==========================================================
	// Sequencer: checks every address of the request, then streams words.
	// Each concern below has its own process; they share the decode that follows.

	// The word counter reaches its final step when one word is left.
	assign lastStep = (remaining == 16'h0001);

	// A check cycle fails on an early fault or on an address outside the map.
	assign checkFail = (state == GDR_CHECK) &&
	                   ((preCode != gdr_pkg::EXC_NONE) || !isMapped(curAddr));

	// The final word of an answer leaves the stream state.
	assign streamDone = (state == GDR_STREAM) && lastStep;

	// Control state: idle, then the address checks, then the word stream.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state <= GDR_IDLE;
		else
		begin
			case (state)
				GDR_IDLE:
				begin
					if (accept)
						state <= GDR_CHECK;
				end
				GDR_CHECK:
				begin
					if (checkFail)
						state <= GDR_IDLE;
					else if (lastStep)
						state <= GDR_STREAM;
				end
				GDR_STREAM:
				begin
					if (lastStep)
						state <= GDR_IDLE;
				end
				default:
					state <= GDR_IDLE;
			endcase
		end
	end

	// Request capture: keeps the fields that the later cycles still need.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			startAddr <= 16'h0000;
			quantity  <= 16'h0000;
			reqFunc   <= 8'h00;
			preCode   <= 8'h00;
		end
		else if (accept)
		begin
			// The front end already subtracted the 40001 base.
			startAddr <= req.startAddr;
			quantity  <= req.quantity;
			reqFunc   <= req.func;
			preCode   <= next_preCode;
		end
	end

	// Address walker: steps through the request once to check it, once to stream it.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			curAddr   <= 16'h0000;
			remaining <= 16'h0000;
		end
		else if (accept)
		begin
			curAddr   <= req.startAddr;
			remaining <= req.quantity;
		end
		else if ((state == GDR_CHECK) && !checkFail && lastStep)
		begin
			// Every address passed, so the walker rewinds for the stream.
			curAddr   <= startAddr;
			remaining <= quantity;
		end
		else if (((state == GDR_CHECK) && !checkFail) || (state == GDR_STREAM))
		begin
			curAddr   <= curAddr + 16'h0001;
			remaining <= remaining - 16'h0001;
		end
	end

	// Handshake: ready while idle, low from the accepting edge to the answer.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reqReady <= 1'b0;
		else if (accept)
			reqReady <= 1'b0;
		else if ((state != GDR_CHECK) && (state != GDR_STREAM))
			reqReady <= 1'b1;
		else if (checkFail || streamDone)
			reqReady <= 1'b1;
	end

	// Word output: one word a cycle in ascending order, high byte in word[15:8].
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			respValid <= 1'b0;
			resp      <= '0;
		end
		else
		begin
			respValid <= (state == GDR_STREAM);
			if (state == GDR_STREAM)
			begin
				resp.word <= snapWords[curAddr[4:0]];
				resp.last <= lastStep;
			end
		end
	end

	// Exception output: an early fault code takes precedence over an address fault.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			excValid <= 1'b0;
			exc      <= '0;
		end
		else
		begin
			excValid <= checkFail;
			if (checkFail)
			begin
				exc.func <= reqFunc + gdr_pkg::EXC_FUNC_FLAG;
				if (preCode != gdr_pkg::EXC_NONE)
					exc.code <= preCode;
				else
					exc.code <= gdr_pkg::EXC_ILLEGAL_ADDR;
			end
		end
	end

endmodule

// File: dv/gdr_readback_registers_asserts.sv
module gdr_readback_registers_asserts (
	// Clock and reset.
	input wire logic                 clk,
	input wire logic                 reset,
	// Request side.
	input wire gdr_pkg::gdr_values_t values,
	input wire logic                 reqValid,
	input wire gdr_pkg::gdr_req_t    req,
	input wire logic                 reqReady,
	// Answer side.
	input wire logic                 respValid,
	input wire gdr_pkg::gdr_resp_t   resp,
	input wire logic                 excValid,
	input wire gdr_pkg::gdr_exc_t    exc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       taken;
	logic [7:0] takenFunc;
	// A request is taken when both handshake lines are high.
	assign taken = reqValid && reqReady;
	// Keeps the function code of the request being answered.
	always_ff @(posedge clk or posedge reset)
		if (reset)
			takenFunc <= 8'h00;
		else if (taken)
			takenFunc <= req.func;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// A one-word read of a given address is taken.
	sequence sReadOne(logic [15:0] a);
		taken && req.func == gdr_pkg::FUNC_READ_HOLDING && req.startAddr == a
			&& req.quantity == 16'h0001;
	endsequence
	// The final word of an answer carries the given value.
	sequence sLastWord(logic [15:0] w);
		respValid && resp.last && resp.word == w;
	endsequence
	// ==========================================================
	// Answer checks.
	a_exc_func_flag: assert property (excValid |-> exc.func == takenFunc + 8'h80)
		else $error("exception function code wrong");
	a_flow_first: assert property (sReadOne(16'h0000) |-> ##3 sLastWord($past(values.flowRate, 3)))
		else $error("flow rate word wrong or late");
	a_test_mode_word: assert property (sReadOne(16'h0010) |-> ##3 sLastWord({15'h0000, $past(values.testModeActive, 3)}))
		else $error("test mode word wrong or late");
	a_unmapped_hole: assert property (sReadOne(16'h0007) |-> ##2 excValid && exc.code == gdr_pkg::EXC_ILLEGAL_ADDR)
		else $error("hole address not refused");
	a_bad_function: assert property (taken && req.func != gdr_pkg::FUNC_READ_HOLDING |-> ##2 excValid)
		else $error("foreign function not refused");
	a_ready_drops: assert property (taken |=> !reqReady && !respValid && !excValid)
		else $error("second request could overlap");
	a_answer_frees: assert property (excValid || (respValid && resp.last) |-> reqReady)
		else $error("bank not idle after answer");
	a_words_burst: assert property (respValid && !resp.last |=> respValid && !excValid)
		else $error("burst words not consecutive");
endmodule

bind gdr_readback_registers gdr_readback_registers_asserts chk (.clk(clk), .reset(reset),
	.values(values), .reqValid(reqValid), .req(req), .reqReady(reqReady),
	.respValid(respValid), .resp(resp), .excValid(excValid), .exc(exc));

// File: dv/gdr_master_model.sv
module gdr_master_model (
	// Clock.
	input wire logic          clk,
	// Request toward the register bank.
	input wire logic          reqReady,
	output logic              reqValid,
	output gdr_pkg::gdr_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines start idle.
	initial
	begin
		reqValid = 1'b0;
		req = '0;
	end
	// Holds one request until taken or for at most 100 cycles, then shows the inverse so stale values never pass.
	task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n,
		output logic ok);
		ok = 1'b0;
		@(posedge clk);
		#1;
		reqValid = 1'b1;
		req = '{func: f, startAddr: a, quantity: n};
		for (int i = 0; i < 100 && !ok; i++)
			@(posedge clk) ok = reqReady;
		#1;
		reqValid = 1'b0;
		req = ~req;
	endtask
endmodule

// File: dv/gdr_readback_registers_test.sv
module gdr_readback_registers_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [15:0] word;
	} gdr_row_t;
	logic                 clk;
	logic                 reset;
	gdr_pkg::gdr_values_t values;
	logic                 reqValid;
	gdr_pkg::gdr_req_t    req;
	logic                 reqReady;
	logic                 respValid;
	gdr_pkg::gdr_resp_t   resp;
	logic                 excValid;
	gdr_pkg::gdr_exc_t    exc;
	logic [15:0]          got[$];
	logic                 gotLast;
	logic                 ok;
	int                   excSeen;
	int                   failures;
	int                   total_checks;
	gdr_row_t             rows[22];
	logic [15:0]          holes[5] = '{16'h0007, 16'h000B, 16'h0017, 16'h0019, 16'h0063};
	// Design and host model.
	gdr_readback_registers uut (.clk(clk), .reset(reset), .values(values),
		.reqValid(reqValid), .req(req), .reqReady(reqReady), .respValid(respValid),
		.resp(resp), .excValid(excValid), .exc(exc));
	gdr_master_model master (.clk(clk), .reqReady(reqReady), .reqValid(reqValid), .req(req));
	// Clock of 40 ns period.
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Records every answer the bank gives.
	always @(posedge clk)
	begin
		if (respValid === 1'b1)
			got.push_back(resp.word);
		if (respValid === 1'b1)
			gotLast = resp.last;
		if (excValid === 1'b1)
			excSeen++;
	end
	// ==========================================================
	// Shared tasks.
	task automatic check(input logic [15:0] a, input logic [15:0] e);
		total_checks++;
		if (a !== e)
		begin
			failures++;
			$display("[FAIL] %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic run(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n, bit d);
		got.delete();
		excSeen = 0;
		master.send(f, a, n, ok);
		if (d)
			values.calGasLevel = 16'hFFFF;
		for (int i = 0; i < 400 && reqReady !== 1'b1; i++)
			@(posedge clk) #1;
		@(posedge clk) #1;
		check({15'h0000, ok}, 16'h0001);
	endtask
	task automatic readWord(input logic [15:0] a, input logic [15:0] e);
		run(gdr_pkg::FUNC_READ_HOLDING, a, 16'h0001, 0);
		check(got[0], e);
		check(16'(excSeen + got.size()), 16'h0001);
	endtask
	task automatic readExc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] n,
		input logic [7:0] c);
		run(f, a, n, 0);
		check({exc.func, exc.code}, {f + 8'h80, c});
		check(16'(excSeen + got.size()), 16'h0001);
	endtask
	task automatic test_done();
		$display("Checks: %0d, failures: %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		#2000000;
		failures++;
		test_done();
	end
	// ==========================================================
	// Main sequence.
	initial
	begin
		values = '{flowRate: 16'h01F4, firstAlarmThreshold: 16'h0019,
			secondAlarmThreshold: 16'h0028, alarmMode: gdr_pkg::GDR_MODE_HL,
			firstAlarmDelay: 16'h0005, secondAlarmDelay: 16'h0007, zeroSuppression: 16'h0015,
			gasName: 64'h5858_5858_5832_4F43, gasNameLength: 4'h3, unit: gdr_pkg::GDR_UNIT_LEL,
			serialChars: 64'h5836_3230_3230_3343, serialLength: 4'h7, testModeActive: 1'b1,
			testGasLevel: 16'h0019, sensorCurrentScaled: 16'h00C8, sensitivityScaled: 16'h0064,
			calCode: 24'h334843, calGasLevel: 16'h004B, linInputPercent: 8'h14,
			linOutputPercent: 8'h28};
		rows = '{'{16'h0000, 16'h01F4}, '{16'h0001, 16'h0019}, '{16'h0002, 16'h0028},
			'{16'h0003, 16'h0002}, '{16'h0004, 16'h0005}, '{16'h0005, 16'h0007},
			'{16'h0006, 16'h0015}, '{16'h0008, 16'h434F}, '{16'h0009, 16'h3220},
			'{16'h000A, 16'h0028}, '{16'h000C, 16'h4333}, '{16'h000D, 16'h3032},
			'{16'h000E, 16'h3032}, '{16'h000F, 16'h3620}, '{16'h0010, 16'h0001},
			'{16'h0011, 16'h0019}, '{16'h0012, 16'h00C8}, '{16'h0013, 16'h0064},
			'{16'h0014, 16'h4348}, '{16'h0015, 16'h3320}, '{16'h0016, 16'h004B},
			'{16'h0018, 16'h1428}};
		reset = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		reset = 1'b0;
		// Every mapped word read alone.
		foreach (rows[i])
			readWord(rows[i].addr, rows[i].word);
		// Burst whose source changes after it is taken still returns the snapshot in order.
		run(gdr_pkg::FUNC_READ_HOLDING, 16'h000C, 16'h000B, 1);
		for (int i = 0; i < 11; i++)
			check(got[i], rows[i + 10].word);
		check({15'h0000, gotLast}, 16'h0001);
		values.calGasLevel = 16'h004B;
		// Unmapped places, a burst running into a hole, foreign functions and counts.
		foreach (holes[i])
			readExc(gdr_pkg::FUNC_READ_HOLDING, holes[i], 16'h0001, gdr_pkg::EXC_ILLEGAL_ADDR);
		readExc(gdr_pkg::FUNC_READ_HOLDING, 16'h0005, 16'h0003, gdr_pkg::EXC_ILLEGAL_ADDR);
		readExc(gdr_pkg::FUNC_READ_HOLDING, 16'h0000, 16'h007D, gdr_pkg::EXC_ILLEGAL_ADDR);
		readExc(8'h10, 16'h0063, 16'h0001, gdr_pkg::EXC_ILLEGAL_FUNC);
		readExc(8'h06, 16'h0000, 16'h0001, gdr_pkg::EXC_ILLEGAL_FUNC);
		readExc(gdr_pkg::FUNC_READ_HOLDING, 16'h0000, 16'h0000, gdr_pkg::EXC_ILLEGAL_VALUE);
		readExc(gdr_pkg::FUNC_READ_HOLDING, 16'h0000, 16'h007E, gdr_pkg::EXC_ILLEGAL_VALUE);
		// A six-character name returns its first four.
		values.gasName = 64'h0000_4E41_4854_454D;
		values.gasNameLength = 4'h6;
		run(gdr_pkg::FUNC_READ_HOLDING, 16'h0008, 16'h0002, 0);
		check(got[0], 16'h4D45);
		check(got[1], 16'h5448);
		// Every unit and alarm mode code, and test mode off.
		for (int i = 0; i < 5; i++)
		begin
			values.unit = gdr_pkg::gdr_unit_t'(i);
			readWord(gdr_pkg::ADDR_UNIT, 16'(10 * i));
		end
		for (int i = 0; i < 3; i++)
		begin
			values.alarmMode = gdr_pkg::gdr_alarm_mode_t'(i);
			readWord(gdr_pkg::ADDR_ALARM_MODE, 16'(i));
		end
		values.testModeActive = 1'b0;
		readWord(gdr_pkg::ADDR_TEST_MODE, 16'h0000);
		// A second reset clears the answer lines, then reads resume.
		reset = 1'b1;
		@(posedge clk) #1;
		check({13'h0000, reqReady, respValid, excValid}, 16'h0000);
		check(exc, 16'h0000);
		reset = 1'b0;
		@(posedge clk) #1;
		check({15'h0000, reqReady}, 16'h0001);
		readWord(gdr_pkg::ADDR_FLOW_RATE, 16'h01F4);
		test_done();
	end
endmodule
